// *** hw/csh_config_status_handshake.v ***
`timescale 1ns/1ns
`include "csh_defs.vh"

module csh_config_status_handshake (
  input wire sysClk,
  input wire reset_n,
  input wire clkEn,
  input wire chipEnableIn_n,
  input wire reconfigRequestIn_n,
  input wire dataComplete,
  input wire dataError,
  input wire loadCompleteLineIn,
  output reg loadCompleteLineOut,
  output reg loadCompleteLineOe,
  input wire configStatusLineIn,
  output reg configStatusLineOut,
  output reg configStatusLineOe,
  input wire chainPassEnable,
  input wire chainGpioOut,
  input wire chainGpioOe,
  output reg chainEnableOut,
  output reg chainEnableOe,
  output reg userMode,
  output reg userPinsTristate,
  output reg errorFlag
);

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  localparam [2:0] ST_POR = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_INIT = 3'h3;
  localparam [2:0] ST_USER = 3'h4;
  localparam [2:0] ST_ERROR = 3'h5;
  localparam [2:0] ST_HOLD = 3'h6;

  // ----------------------------------------
  // State decoders
  // ----------------------------------------
  // Load-complete is let go only from init onward
  function releasesDone;
    input [2:0] st;
    begin
      releasesDone = (st == ST_INIT) || (st == ST_USER);
    end
  endfunction

  // Status is pulled during power-on reset and in error
  function pullsStatus;
    input [2:0] st;
    begin
      pullsStatus = (st == ST_POR) || (st == ST_ERROR);
    end
  endfunction

  function isUser;
    input [2:0] st;
    begin
      isUser = (st == ST_USER);
    end
  endfunction

  function isError;
    input [2:0] st;
    begin
      isError = (st == ST_ERROR);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [2:0] state;
  reg [2:0] next_state;
  reg [`CSH_CNT_W-1:0] count;
  reg [`CSH_CNT_W-1:0] next_count;
  reg reqPrev;
  reg configDone;
  reg next_configDone;

  // ----------------------------------------
  // Qualifiers
  // ----------------------------------------
  // Reset value of reqPrev matches the idle level: no false edge
  wire reqFall = reqPrev & ~reconfigRequestIn_n;
  wire inLoadOrInit = (state == ST_LOAD) || (state == ST_INIT);
  // Only count an external pull-down when we are not pulling ourselves
  wire extStatusLow = ~configStatusLineIn & ~configStatusLineOe &
    inLoadOrInit;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always @* begin
    next_state = state;
    next_count = count;
    next_configDone = configDone;
    case (state)
      ST_POR: begin
        if (count == `CSH_POR_CYC - 1) begin
          next_state = ST_IDLE;
          next_count = {`CSH_CNT_W{1'b0}};
        end else begin
          next_count = count + 1'b1;
        end
      end
      ST_IDLE: begin
        if (!chipEnableIn_n) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (chipEnableIn_n) begin
          next_state = ST_IDLE;
        end else if (dataError || extStatusLow) begin
          // Error wins over a completion in the same cycle
          next_state = ST_ERROR;
        end else if (dataComplete) begin
          next_state = ST_INIT;
          next_count = {`CSH_CNT_W{1'b0}};
        end
      end
      ST_INIT: begin
        if (extStatusLow) begin
          next_state = ST_ERROR;
        end else if (!loadCompleteLineIn) begin
          // Host still holding the line low: wait, initialise later
          next_count = {`CSH_CNT_W{1'b0}};
        end else if (count == `CSH_INIT_CYC - 1) begin
          next_state = ST_USER;
          next_configDone = 1'b1;
        end else begin
          next_count = count + 1'b1;
        end
      end
      ST_USER: begin
        next_state = ST_USER;
      end
      ST_ERROR: begin
        next_state = ST_ERROR;
      end
      ST_HOLD: begin
        next_configDone = 1'b0;
        if (reconfigRequestIn_n) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    // Reconfig request overrides any state except power-on reset
    if (state != ST_POR && (reqFall || !reconfigRequestIn_n)) begin
      next_state = ST_HOLD;
      next_configDone = 1'b0;
      next_count = {`CSH_CNT_W{1'b0}};
    end
  end

  // ----------------------------------------
  // Registers and pin drivers
  // ----------------------------------------
  always @(posedge sysClk) begin
    if (!reset_n) begin
      state <= ST_POR;
      count <= {`CSH_CNT_W{1'b0}};
      reqPrev <= 1'b1;
      configDone <= 1'b0;
      loadCompleteLineOut <= 1'b0;
      loadCompleteLineOe <= 1'b1;
      configStatusLineOut <= 1'b0;
      configStatusLineOe <= 1'b1;
      chainEnableOut <= 1'b0;
      chainEnableOe <= 1'b0;
      userMode <= 1'b0;
      userPinsTristate <= 1'b1;
      errorFlag <= 1'b0;
    end else if (clkEn) begin
      state <= next_state;
      count <= next_count;
      reqPrev <= reconfigRequestIn_n;
      configDone <= next_configDone;
      // Released only from init onward, and never in error
      loadCompleteLineOut <= 1'b0;
      loadCompleteLineOe <= !releasesDone(next_state);
      configStatusLineOut <= 1'b0;
      configStatusLineOe <= pullsStatus(next_state);
      if (chainPassEnable) begin
        chainEnableOut <= 1'b0;
        chainEnableOe <= next_configDone &&
          !isError(next_state);
      end else begin
        // Plain I/O only once the device runs the user design
        chainEnableOut <= chainGpioOut;
        chainEnableOe <= chainGpioOe && isUser(next_state);
      end
      userMode <= isUser(next_state);
      userPinsTristate <= !isUser(next_state);
      errorFlag <= isError(next_state);
    end
  end

endmodule // csh_config_status_handshake

// *** hw/csh_defs.vh ***
`ifndef CSH_DEFS_VH
`define CSH_DEFS_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CSH_CLK_MHZ    20
`define CSH_POR_NS     1000
`define CSH_POR_CYC    ((`CSH_POR_NS * `CSH_CLK_MHZ + 999) / 1000)
`define CSH_INIT_NS    500
`define CSH_INIT_CYC   ((`CSH_INIT_NS * `CSH_CLK_MHZ + 999) / 1000)
`define CSH_CNT_W      8

`endif

// *** sim/csh_asserts.sv ***
`timescale 1ns/1ns
module csh_asserts (
  input wire sysClk,
  input wire reset_n,
  input wire chipEnableIn_n,
  input wire reconfigRequestIn_n,
  input wire dataComplete,
  input wire dataError,
  input wire chainPassEnable,
  input wire loadCompleteLineOe,
  input wire configStatusLineOe,
  input wire chainEnableOut,
  input wire chainEnableOe,
  input wire userMode,
  input wire userPinsTristate,
  input wire errorFlag
);
  default clocking @(posedge sysClk); endclocking
  default disable iff (!reset_n);
  property p_rel;
    $fell(loadCompleteLineOe) |-> $past(dataComplete);
  endproperty
  a_rel: assert property (p_rel) else $error("early release");
  property p_od; $past(chainPassEnable) |-> !chainEnableOut; endproperty
  a_od: assert property (p_od) else $error("chain drives high");
  property p_por; $rose(reset_n) |-> configStatusLineOe [*8]; endproperty
  a_por: assert property (p_por) else $error("status freed early");
  property p_err;
    $rose(errorFlag) |-> configStatusLineOe && loadCompleteLineOe;
  endproperty
  a_err: assert property (p_err) else $error("error not shown");
  property p_stk; errorFlag && reconfigRequestIn_n |=> errorFlag; endproperty
  a_stk: assert property (p_stk) else $error("error left");
  property p_chn;
    errorFlag && $past(chainPassEnable) |-> !chainEnableOe;
  endproperty
  a_chn: assert property (p_chn) else $error("chain on in error");
  property p_rcf; !reconfigRequestIn_n |=> !userMode && userPinsTristate;
  endproperty
  a_rcf: assert property (p_rcf) else $error("reconfig ignored");
  property p_ce; chipEnableIn_n |=> !$fell(loadCompleteLineOe); endproperty
  a_ce: assert property (p_ce) else $error("loaded while off");
  c_user: cover property ($rose(userMode));
  c_err: cover property ($rose(errorFlag));
  c_gpio: cover property (!chainPassEnable && chainEnableOe);
endmodule // csh_asserts
bind csh_config_status_handshake csh_asserts u_chk (.*);

// *** sim/csh_host_model.sv ***
`timescale 1ns/1ns
module csh_host_model (
  input wire doneOe,
  input wire statOe,
  input wire forceErr,
  input wire chainOe,
  input wire chainOut,
  output wire doneLine,
  output wire statLine,
  output wire nextCe_n
);
  // Pull-ups: a released line reads high
  assign doneLine = !doneOe;
  assign statLine = !(statOe || forceErr);
  assign nextCe_n = chainOe ? chainOut : 1'h1;
endmodule // csh_host_model

// *** sim/csh_config_status_handshake_tb.sv ***
`timescale 1ns/1ns
module csh_config_status_handshake_tb;
  reg sysClk = 1'h0, reset_n = 1'h0, ceN = 1'h1, rqN = 1'h1, dc = 1'h0;
  reg de = 1'h0, pass = 1'h1, gOut = 1'h0, gOe = 1'h0, forceErr = 1'h0;
  wire dOut, dOe, sOut, sOe, cOut, cOe, user, tri3, err, dL, sL, chip_enable_in;
  int fails = 0, total_checks = 0;
  always #25 sysClk = !sysClk;
  csh_config_status_handshake dut_u (.sysClk(sysClk), .reset_n(reset_n),
    .clkEn(1'h1), .chipEnableIn_n(ceN), .reconfigRequestIn_n(rqN),
    .dataComplete(dc), .dataError(de), .loadCompleteLineIn(dL),
    .loadCompleteLineOut(dOut), .loadCompleteLineOe(dOe),
    .configStatusLineIn(sL), .configStatusLineOut(sOut),
    .configStatusLineOe(sOe), .chainPassEnable(pass), .chainGpioOut(gOut),
    .chainGpioOe(gOe), .chainEnableOut(cOut), .chainEnableOe(cOe),
    .userMode(user), .userPinsTristate(tri3), .errorFlag(err));
  csh_host_model host_u (.doneOe(dOe), .statOe(sOe), .forceErr(forceErr),
    .chainOe(cOe), .chainOut(cOut), .doneLine(dL), .statLine(sL),
    .nextCe_n(chip_enable_in));
  task cyc(input int n); repeat (n) @(posedge sysClk); #1; endtask
  task chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reconfig pulse, then back to loading
  task clr;
    @(posedge sysClk) rqN <= 1'h0;
    cyc(2); chk(user, 1'h0); chk(tri3, 1'h1);
    @(posedge sysClk) rqN <= 1'h1;
    cyc(3); chk(err, 1'h0);
  endtask
  task t_load;
    @(posedge sysClk) ceN <= 1'h0;
    cyc(3); chk(dOe, 1'h1);
    @(posedge sysClk) dc <= 1'h1;
    @(posedge sysClk) dc <= 1'h0;
    #1 chk(dOe, 1'h0);
    for (int i = 0; i < 30 && !user; i++) cyc(1);
    chk(user, 1'h1); chk(tri3, 1'h0);
    chk(cOe, 1'h1); chk(cOut, 1'h0); chk(chip_enable_in, 1'h0);
  endtask
  task t_err;
    clr;
    @(posedge sysClk) de <= 1'h1;
    @(posedge sysClk) de <= 1'h0;
    #1 chk(err, 1'h1); chk(sOe, 1'h1);
    cyc(5); chk(dOe, 1'h1); chk(cOe, 1'h0);
    clr;
    @(posedge sysClk) forceErr <= 1'h1;
    cyc(2); chk(err, 1'h1);
    @(posedge sysClk) forceErr <= 1'h0;
    clr;
  endtask
  task t_ce;
    @(posedge sysClk) ceN <= 1'h1;
    cyc(2);
    @(posedge sysClk) dc <= 1'h1;
    @(posedge sysClk) dc <= 1'h0;
    cyc(2); chk(dOe, 1'h1); chk(user, 1'h0);
    @(posedge sysClk) {pass, gOe, gOut} <= 3'h3;
    ceN <= 1'h0;
    cyc(2);
    @(posedge sysClk) dc <= 1'h1;
    @(posedge sysClk) dc <= 1'h0;
    for (int i = 0; i < 30 && !user; i++) cyc(1);
    chk(user, 1'h1);
    chk(cOe, 1'h1); chk(cOut, 1'h1);
  endtask
  initial begin
    repeat (8) @(posedge sysClk);
    reset_n <= 1'h1;
    cyc(2); chk(sOe, 1'h1);
    cyc(25); chk(sOe, 1'h0);
    t_load;
    t_err;
    t_ce;
    results;
  end
endmodule // csh_config_status_handshake_tb
